// [hw/wtls_pkg.sv]
// Package for the weighing tare and level supervision block.
// Assumes one 20 MHz clock; all weights are signed fixed-width words.
`default_nettype none
package wtls_pkg;
    localparam int WEIGHT_W = 24;
    localparam int DAC_W = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int SELFTEST_MS = 5000;
    localparam longint SELFTEST_CYCLES_L = (longint'(SELFTEST_MS) * CLK_HZ) / 1000;
    localparam int SELFTEST_CYCLES = int'(SELFTEST_CYCLES_L);
    localparam logic [WEIGHT_W-1:0] TARE_RESET = 24'h000000;
    localparam logic [DAC_W-1:0] DAC_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        WTLS_SRC_MVV, WTLS_SRC_NET, WTLS_SRC_GROSS, WTLS_SRC_SHOWN,
        WTLS_SRC_ABS_NET, WTLS_SRC_ABS_GROSS, WTLS_SRC_ABS_SHOWN
    } wtls_src_t;

    typedef struct packed {
        wtls_src_t source;
        logic setpointMode;
        logic activeBelow;
        logic signed [WEIGHT_W-1:0] level;
        logic signed [WEIGHT_W-1:0] hyst;
    } wtls_chan_cfg_t;

    typedef struct packed {
        logic above;
        logic relay;
    } wtls_chan_stat_t;
endpackage : wtls_pkg
`default_nettype wire

// [hw/wtls_top.sv]
// Tare, net/gross, zero, analogue forcing and two level supervision channels.
// Assumes synchronous inputs, one sample strobe per new measurement.
`default_nettype none
module wtls_top #(
    parameter int SELFTEST_CYCLES = wtls_pkg::SELFTEST_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic selfTestFail,
    input wire logic [7:0] selfTestCode,
    input wire logic autoStart,
    input wire logic enterKey,
    input wire logic sampleStrobe,
    input wire logic weightValid,
    input wire logic instrumentError,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] rawWeight,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] mvvSignal,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] anaFiltWeight,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] digFiltWeight,
    input wire logic anaFilterWider,
    input wire logic tare_input,
    input wire logic gross_net_select_input,
    input wire logic zeroRequest,
    input wire logic zeroViewEnable,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] anaLowWeight,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] anaHighWeight,
    input wire logic anaFixedMode,
    input wire logic [wtls_pkg::DAC_W-1:0] anaFixedLevel,
    input wire wtls_pkg::wtls_chan_cfg_t chanCfg [2],
    input wire logic cfgReload,
    input wire logic [1:0] hostLevelWrite,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] hostLevel,
    input wire logic inProcess,
    input wire logic [1:0] relaySrcChannel,
    output logic operating,
    output logic waitStart,
    output logic startError,
    output logic [7:0] errorCode,
    output logic netShown,
    output logic signed [wtls_pkg::WEIGHT_W-1:0] tareValue,
    output logic signed [wtls_pkg::WEIGHT_W-1:0] zeroOffset,
    output logic signed [wtls_pkg::WEIGHT_W-1:0] netWeight,
    output logic signed [wtls_pkg::WEIGHT_W-1:0] shownWeight,
    output logic [wtls_pkg::DAC_W-1:0] anaOut,
    output wtls_pkg::wtls_chan_stat_t chanStat [2],
    output logic signed [wtls_pkg::WEIGHT_W-1:0] activeLevel [2],
    output logic relay_one,
    output logic relay_two
);
    localparam int W = wtls_pkg::WEIGHT_W;
    localparam int DW = wtls_pkg::DAC_W;

    typedef enum logic [1:0] {WTLS_TEST, WTLS_WAIT, WTLS_RUN, WTLS_FAIL} wtls_state_t;
    wtls_state_t state_reg;
    logic [31:0] testCnt_reg;
    logic tarePrev_reg;
    logic selPrev_reg;
    logic signed [W-1:0] gross;
    logic signed [W-1:0] netCalc;
    logic signed [W-1:0] superIn;
    logic [DW-1:0] scaled;
    logic [1:0] chanOut;
    logic tareEdge;
    logic viewEdge;

    // Magnitude saturates: the most negative word has no positive twin
    function automatic logic signed [W-1:0] wtls_abs(input logic signed [W-1:0] v);
        logic signed [W-1:0] r;
        if (v == {1'b1, {(W-1){1'b0}}}) begin
            r = {1'b0, {(W-1){1'b1}}};
        end else if (v < 0) begin
            r = -v;
        end else begin
            r = v;
        end
        return r;
    endfunction : wtls_abs

    // Start-up: self-test count, then run or wait for enter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= WTLS_TEST;
            testCnt_reg <= 32'h00000000;
            errorCode <= 8'h00;
        end else begin
            case (state_reg)
                WTLS_TEST: begin
                    if (selfTestFail) begin
                        state_reg <= WTLS_FAIL;
                        errorCode <= selfTestCode;
                    end else if (testCnt_reg >= 32'(SELFTEST_CYCLES - 1)) begin
                        state_reg <= autoStart ? WTLS_RUN : WTLS_WAIT;
                    end else begin
                        testCnt_reg <= testCnt_reg + 32'h00000001;
                    end
                end
                WTLS_WAIT: begin
                    if (enterKey) begin
                        state_reg <= WTLS_RUN;
                    end
                end
                WTLS_RUN: state_reg <= WTLS_RUN;
                WTLS_FAIL: state_reg <= WTLS_FAIL;
                default: state_reg <= WTLS_TEST;
            endcase
        end
    end

    assign operating = (state_reg == WTLS_RUN);
    assign waitStart = (state_reg == WTLS_WAIT);
    assign startError = (state_reg == WTLS_FAIL);

    // Gross after zero offset, net after tare
    assign gross = rawWeight - zeroOffset;
    assign netCalc = gross - tareValue;

    // Rising edges of the two digital inputs
    assign tareEdge = tare_input && !tarePrev_reg;
    assign viewEdge = gross_net_select_input && !selPrev_reg;

    // Tare capture and zero setting share the tare register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tareValue <= wtls_pkg::TARE_RESET;
            zeroOffset <= wtls_pkg::TARE_RESET;
            tarePrev_reg <= 1'b0;
        end else begin
            tarePrev_reg <= tare_input;
            if (operating && zeroRequest && zeroViewEnable && !netShown && weightValid) begin
                zeroOffset <= rawWeight;
                tareValue <= wtls_pkg::TARE_RESET;
            end else if (operating && tareEdge && weightValid) begin
                tareValue <= gross;
            end
        end
    end

    // Net indicator: set by tare, flipped by view input
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            netShown <= 1'b0;
            selPrev_reg <= 1'b0;
        end else begin
            selPrev_reg <= gross_net_select_input;
            if (operating && tareEdge && weightValid) begin
                netShown <= 1'b1;
            end else if (operating && viewEdge) begin
                netShown <= !netShown;
            end
        end
    end

    // Registered weights for display and host
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            netWeight <= '0;
            shownWeight <= '0;
        end else begin
            netWeight <= netCalc;
            shownWeight <= netShown ? netCalc : gross;
        end
    end

    // Linear span from low weight to high weight, clamped at both ends
    always_comb begin
        logic signed [W:0] span;
        logic signed [W:0] off;
        logic [W+DW:0] prod;
        span = (W+1)'(anaHighWeight) - (W+1)'(anaLowWeight);
        off = (W+1)'(shownWeight) - (W+1)'(anaLowWeight);
        prod = '0;
        if (span <= 0 || off <= 0) begin
            scaled = '0;
        end else if (off >= span) begin
            scaled = '1;
        end else begin
            prod = (W+DW+1)'(off) * (W+DW+1)'({DW{1'b1}});
            scaled = DW'(prod / (W+DW+1)'(span));
        end
    end

    // Error and start-up force the output to zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            anaOut <= wtls_pkg::DAC_ZERO;
        end else if (instrumentError || !operating) begin
            anaOut <= wtls_pkg::DAC_ZERO;
        end else if (anaFixedMode) begin
            anaOut <= anaFixedLevel;
        end else begin
            anaOut <= scaled;
        end
    end

    // Faster of the two filters feeds supervision
    assign superIn = anaFilterWider ? anaFiltWeight : digFiltWeight;

    // Two identical supervision channels
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            logic signed [W-1:0] sig;
            logic signed [W-1:0] gSel;
            logic signed [W:0] ptLo;
            logic signed [W:0] ptHi;
            logic signed [W:0] sigX;
            logic aboveState_reg;
            always_comb begin
                gSel = superIn - zeroOffset;
                case (chanCfg[c].source)
                    wtls_pkg::WTLS_SRC_MVV: sig = mvvSignal;
                    wtls_pkg::WTLS_SRC_NET: sig = gSel - tareValue;
                    wtls_pkg::WTLS_SRC_GROSS: sig = gSel;
                    wtls_pkg::WTLS_SRC_SHOWN: sig = netShown ? gSel - tareValue : gSel;
                    wtls_pkg::WTLS_SRC_ABS_NET: sig = wtls_abs(gSel - tareValue);
                    wtls_pkg::WTLS_SRC_ABS_GROSS: sig = wtls_abs(gSel);
                    wtls_pkg::WTLS_SRC_ABS_SHOWN:
                        sig = wtls_abs(netShown ? gSel - tareValue : gSel);
                    default: sig = gSel;
                endcase
                sigX = (W+1)'(sig);
                // One point at level, other offset by signed hysteresis
                if (chanCfg[c].hyst >= 0) begin
                    ptLo = (W+1)'(activeLevel[c]);
                    ptHi = (W+1)'(activeLevel[c]) + (W+1)'(chanCfg[c].hyst);
                end else begin
                    ptHi = (W+1)'(activeLevel[c]);
                    ptLo = (W+1)'(activeLevel[c]) + (W+1)'(chanCfg[c].hyst);
                end
            end

            // Threshold: stored value, host may overwrite until reload
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    activeLevel[c] <= '0;
                end else if (cfgReload || state_reg == WTLS_TEST) begin
                    activeLevel[c] <= chanCfg[c].level;
                end else if (hostLevelWrite[c]) begin
                    activeLevel[c] <= hostLevel;
                end
            end

            // Level comparison only on a new measurement
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    aboveState_reg <= 1'b0;
                end else if (operating && sampleStrobe && !chanCfg[c].setpointMode) begin
                    if (sigX >= ptHi) begin
                        aboveState_reg <= 1'b1;
                    end else if (sigX < ptLo) begin
                        aboveState_reg <= 1'b0;
                    end
                end
            end

            // Polarity and status towards the host
            assign chanOut[c] = chanCfg[c].activeBelow ? !aboveState_reg : aboveState_reg;
            assign chanStat[c].above = aboveState_reg;
            assign chanStat[c].relay = (c == 0) ? relay_one : relay_two;
        end
    endgenerate

    // Relays drop on error and outside operation
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            relay_one <= 1'b0;
            relay_two <= 1'b0;
        end else if (instrumentError || !operating) begin
            relay_one <= 1'b0;
            relay_two <= 1'b0;
        end else begin
            relay_one <= relaySrcChannel[0] ? chanOut[0] : inProcess;
            relay_two <= relaySrcChannel[1] ? chanOut[1] : inProcess;
        end
    end
endmodule : wtls_top
`default_nettype wire

// [testbench/weigh_tare_level_supervision_tb.sv]
// Bench for wtls_top: start-up, tare, zero, supervision, error forcing.
// Assumes a self-test count of 20 and the host model for threshold writes.
`default_nettype none
module weigh_tare_level_supervision_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = wtls_pkg::WEIGHT_W;
    localparam logic [W-1:0] MV [4] = '{24'hffffec, 24'hfffff4, 24'h000000, 24'hfffff4};
    localparam logic [W-1:0] RAW [4] = '{24'h00014a, 24'h000136, 24'h000122, 24'h000136};
    localparam logic [5:0] EXP [4] = '{6'h1f, 6'h1f, 6'h20, 6'h20};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic selfTestFail, autoStart, enterKey, sampleStrobe, instrumentError, tare_input;
    logic gross_net_select_input, zeroRequest, zeroViewEnable, anaFixedMode, cfgReload;
    logic inProcess, go, chan, weightValid, operating, waitStart, startError, netShown;
    logic relay_one, relay_two, anaFilterWider;
    logic [1:0] relaySrcChannel, hostLevelWrite;
    logic [7:0] selfTestCode, errorCode;
    logic [15:0] anaFixedLevel, anaOut;
    logic signed [W-1:0] rawWeight, mvvSignal, level, hostLevel, tareValue, zeroOffset;
    logic signed [W-1:0] netWeight, shownWeight, activeLevel [2];
    wtls_pkg::wtls_chan_cfg_t chanCfg [2];
    wtls_pkg::wtls_chan_stat_t chanStat [2];
    int fails = 0, n_compared = 0, cyc = 0;
    wtls_top #(.SELFTEST_CYCLES(20)) dut (.ref_clk, .sys_rst, .selfTestFail, .selfTestCode,
        .autoStart, .enterKey, .sampleStrobe, .weightValid, .instrumentError, .rawWeight,
        .mvvSignal, .anaFiltWeight(24'h000000), .digFiltWeight(rawWeight),
        .anaFilterWider, .tare_input, .gross_net_select_input, .zeroRequest,
        .zeroViewEnable, .anaLowWeight(24'h000000), .anaHighWeight(24'h0000fa), .anaFixedMode,
        .anaFixedLevel, .chanCfg, .cfgReload, .hostLevelWrite, .hostLevel, .inProcess,
        .relaySrcChannel, .operating, .waitStart, .startError, .errorCode, .netShown,
        .tareValue, .zeroOffset, .netWeight, .shownWeight, .anaOut, .chanStat, .activeLevel,
        .relay_one, .relay_two);
    wtls_host_model host (.ref_clk, .go, .chan, .level, .hostLevelWrite, .hostLevel);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic tally_and_finish();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic restart(input logic fail, input logic autoS);
        sys_rst = 1'b1;
        selfTestFail = fail;
        autoStart = autoS;
        tick(20);
        sys_rst = 1'b0;
        tick(15);
        chk("early start", {operating, waitStart}, 0);
        tick(10);
    endtask : restart
    task automatic rise(ref logic sig);
        sig = 1'b1;
        tick(1);
        sig = 1'b0;
        tick(3);
    endtask : rise
    task automatic sample(input logic [W-1:0] raw, input logic [W-1:0] mv);
        rawWeight = raw;
        mvvSignal = mv;
        rise(sampleStrobe);
    endtask : sample
    initial begin
        {selfTestFail, autoStart, enterKey, sampleStrobe, instrumentError, tare_input} = '0;
        {gross_net_select_input, zeroRequest, zeroViewEnable, anaFixedMode, cfgReload} = '0;
        anaFilterWider = 1'b0;
        {inProcess, go, chan, weightValid, relaySrcChannel, rawWeight, mvvSignal, level} = '0;
        selfTestCode = 8'h5a;
        anaFixedLevel = 16'h1234;
        chanCfg[0] = '{wtls_pkg::WTLS_SRC_MVV, 1'b0, 1'b1, 24'hfffff6, 24'hfffffb};
        chanCfg[1] = '{wtls_pkg::WTLS_SRC_GROSS, 1'b0, 1'b0, 24'h000032, 24'h000014};
        restart(1'b1, 1'b1);
        chk("failed start", {startError, operating, errorCode}, {2'h2, 8'h5a});
        restart(1'b0, 1'b0);
        chk("wait state", {waitStart, operating}, 2'h2);
        rise(enterKey);
        chk("entered", operating, 1);
        rawWeight = 24'h000064;
        rise(tare_input);
        chk("tare invalid", netShown, 0);
        weightValid = 1'b1;
        rise(tare_input);
        chk("tare", {netShown, tareValue}, {1'b1, 24'h000064});
        rawWeight = 24'h0000fa;
        tick(3);
        chk("net", {netWeight, shownWeight}, {24'h000096, 24'h000096});
        zeroViewEnable = 1'b1;
        rise(zeroRequest);
        chk("zero while net", zeroOffset, 0);
        rise(gross_net_select_input);
        chk("gross view", {netShown, shownWeight, anaOut}, {1'b0, 24'h0000fa, 16'hffff});
        zeroViewEnable = 1'b0;
        rise(zeroRequest);
        chk("zero disabled", zeroOffset, 0);
        zeroViewEnable = 1'b1;
        rise(zeroRequest);
        chk("zero", {zeroOffset, tareValue, anaOut}, {24'h0000fa, 24'h000000, 16'h0000});
        relaySrcChannel = 2'h3;
        for (int i = 0; i < 4; i++) begin
            sample(RAW[i], MV[i]);
            chk("supervision", {chanStat[0], chanStat[1], relay_one, relay_two}, EXP[i]);
        end
        chanCfg[0].setpointMode = 1'b1;
        anaFilterWider = 1'b1;
        sample(RAW[0], MV[0]);
        chk("mode and filter", {chanStat[0].above, chanStat[1].above}, 2'h2);
        chanCfg[1].source = wtls_pkg::WTLS_SRC_ABS_GROSS;
        sample(RAW[0], MV[0]);
        chk("absolute source", chanStat[1].above, 1);
        chanCfg[1].source = wtls_pkg::WTLS_SRC_GROSS;
        chanCfg[0].setpointMode = 1'b0;
        anaFilterWider = 1'b0;
        level = 24'h000064;
        chan = 1'b1;
        rise(go);
        chk("host level", activeLevel[1], 24'h000064);
        sample(RAW[0], MV[2]);
        chk("host level used", chanStat[1].above, 0);
        rise(cfgReload);
        chk("level reload", activeLevel[1], 24'h000032);
        relaySrcChannel = 2'h0;
        inProcess = 1'b1;
        anaFixedMode = 1'b1;
        tick(3);
        chk("in-process relays", {relay_one, relay_two, anaOut}, {2'h3, 16'h1234});
        instrumentError = 1'b1;
        tick(3);
        chk("error outputs", {relay_one, relay_two, anaOut}, 0);
        instrumentError = 1'b0;
        restart(1'b0, 1'b1);
        chk("auto start", operating, 1);
        tally_and_finish();
    end
endmodule : weigh_tare_level_supervision_tb
`default_nettype wire

// [testbench/wtls_assertions.sv]
// Port-level assertions for wtls_top.
// Assumes a bind into wtls_top that passes SELFTEST_CYCLES on.
`default_nettype none
module wtls_assertions #(parameter int SELFTEST_CYCLES = 20, localparam int W = wtls_pkg::WEIGHT_W) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic operating,
    input wire logic startError,
    input wire logic weightValid,
    input wire logic tare_input,
    input wire logic gross_net_select_input,
    input wire logic zeroRequest,
    input wire logic zeroViewEnable,
    input wire logic sampleStrobe,
    input wire logic instrumentError,
    input wire logic signed [W-1:0] rawWeight,
    input wire logic signed [W-1:0] mvvSignal,
    input wire wtls_pkg::wtls_chan_cfg_t chanCfg [2],
    input wire logic netShown,
    input wire logic signed [W-1:0] tareValue,
    input wire logic signed [W-1:0] zeroOffset,
    input wire logic [wtls_pkg::DAC_W-1:0] anaOut,
    input wire wtls_pkg::wtls_chan_stat_t chanStat [2],
    input wire logic signed [W-1:0] activeLevel [2],
    input wire logic relay_one,
    input wire logic relay_two
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    int stCnt;
    logic signed [W-1:0] hiPt, loPt;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) stCnt <= 0;
        else if (stCnt < SELFTEST_CYCLES) stCnt <= stCnt + 1;
    end
    // Switching points of channel one
    assign hiPt = chanCfg[0].hyst < 0 ? activeLevel[0] : activeLevel[0] + chanCfg[0].hyst;
    assign loPt = chanCfg[0].hyst < 0 ? activeLevel[0] + chanCfg[0].hyst : activeLevel[0];
    selftest_hold_a: assert property (stCnt < SELFTEST_CYCLES - 1 |-> !operating)
        else $error("operating before self-test time ran out");
    fail_halts_a: assert property (startError |=> startError && !operating)
        else $error("start-up went on after a failed self-test");
    tare_capture_a: assert property (operating && weightValid && $rose(tare_input)
        && !zeroRequest |=> netShown && tareValue == $past(rawWeight - zeroOffset))
        else $error("tare not captured from gross");
    zero_clear_a: assert property (operating && zeroRequest && zeroViewEnable && weightValid
        && !netShown |=> tareValue == wtls_pkg::TARE_RESET && zeroOffset == $past(rawWeight))
        else $error("zero setting left tare or offset wrong");
    toggle_view_a: assert property (operating && $rose(gross_net_select_input)
        && !$rose(tare_input) |=> netShown != $past(netShown))
        else $error("net/gross view did not toggle");
    err_outputs_a: assert property (instrumentError [*2] |-> !relay_one && !relay_two
        && anaOut == wtls_pkg::DAC_ZERO)
        else $error("error did not clear relays and analogue output");
    above_set_a: assert property (operating && sampleStrobe && mvvSignal >= hiPt
        && chanCfg[0].source == wtls_pkg::WTLS_SRC_MVV && !chanCfg[0].setpointMode
        |=> chanStat[0].above)
        else $error("channel one not above at upper point");
    above_hold_a: assert property (operating && sampleStrobe && mvvSignal >= loPt
        && mvvSignal < hiPt && chanCfg[0].source == wtls_pkg::WTLS_SRC_MVV
        |=> $stable(chanStat[0].above))
        else $error("channel one changed inside hysteresis band");
    cover property (startError);
    cover property (operating && weightValid && $rose(tare_input));
    cover property (operating && sampleStrobe && mvvSignal >= loPt && mvvSignal < hiPt);
endmodule : wtls_assertions
bind wtls_top wtls_assertions #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) chk (.ref_clk, .sys_rst,
    .operating, .startError, .weightValid, .tare_input, .gross_net_select_input, .zeroRequest,
    .zeroViewEnable, .sampleStrobe, .instrumentError, .rawWeight, .mvvSignal, .chanCfg,
    .netShown, .tareValue, .zeroOffset, .anaOut, .chanStat, .activeLevel, .relay_one, .relay_two);
`default_nettype wire

// [testbench/wtls_host_model.sv]
// Host master model: temporary threshold writes to one channel.
// Assumes go is raised for one cycle between falling edges.
`default_nettype none
module wtls_host_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic chan,
    input wire logic signed [wtls_pkg::WEIGHT_W-1:0] level,
    output logic [1:0] hostLevelWrite,
    output logic signed [wtls_pkg::WEIGHT_W-1:0] hostLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial hostLevelWrite = 2'h0;
    initial hostLevel = 24'h000000;
    // Idle bus inverts the last value every cycle
    always @(posedge ref_clk) begin
        hostLevelWrite <= go ? 2'h1 << chan : 2'h0;
        hostLevel <= go ? level : ~hostLevel;
    end
endmodule : wtls_host_model
`default_nettype wire
